// ==== rtl/fca_pkg.sv ====
// Purpose: shared constants and types for the flash cpu access path
// Assumes: one core clock, cpu byte addresses of 32 bits
// Notes: flash macro addresses are 22 bits wide

package fca_pkg;

  // ************************************************************
  // access width modes and link operations
  // ************************************************************
  typedef enum logic [1:0] {FCA_MODE64, FCA_MODE32, FCA_MODE16, FCA_MODE_BAD} fca_mode_e;
  typedef enum logic [1:0] {FCA_OP_READ, FCA_OP_WRITE, FCA_OP_FETCH, FCA_OP_NONE} fca_op_e;

  // timing fields as the macro sees them
  typedef struct packed {
    logic [3:0] rd_wait;   // read wait cycle count
    logic [3:0] wr_wait;   // write wait cycle count
    logic td_rd;           // transition detect for reads
    logic td_wr;           // transition detect for writes
    logic address_latch_hold_setting;            // address latch hold
    logic [1:0] eq;        // equalize
    logic wsh;             // write strobe high
  } fca_timing_s;

  // ************************************************************
  // address translation constants
  // ************************************************************
  localparam int FCA_FA_W = 22;
  localparam logic [31:0] FCA_S8_LO = 32'h0014_0000;
  localparam logic [31:0] FCA_S8_HI = 32'h0014_FFFF;
  localparam logic [31:0] FCA_S8_WIN = 32'h0000_4000;
  localparam logic [31:0] FCA_S8_ODD = 32'h0000_2000;
  localparam logic [31:0] FCA_S8_ADJ = 32'h0005_0000;
  localparam logic [31:0] FCA_S64_LO = 32'h0004_0000;
  localparam logic [31:0] FCA_S64_HI = 32'h0013_FFFF;
  localparam logic [31:0] FCA_S64_WIN = 32'h0002_0000;
  localparam logic [31:0] FCA_S64_ODD = 32'h0001_0000;
  localparam logic [31:0] FCA_S64_ADJ = 32'h000C_0000;
  localparam logic [31:0] FCA_SV_LO = 32'h0014_8000;
  localparam logic [31:0] FCA_SV_HI = 32'h0014_800F;
  localparam logic [21:0] FCA_PROG_OFS = 22'h20_0000;

  // ************************************************************
  // timing presets by core clock ceiling in MHz
  // ************************************************************
  localparam logic [6:0] FCA_RD_C1 = 7'h18;   // 24 MHz
  localparam logic [6:0] FCA_RD_C2 = 7'h30;   // 48 MHz
  localparam logic [3:0] FCA_RD_W1 = 4'h1;
  localparam logic [3:0] FCA_RD_W2 = 4'h2;
  localparam logic [3:0] FCA_RD_W3 = 4'h4;
  localparam logic [1:0] FCA_EQ2 = 2'h1;
  localparam logic [1:0] FCA_EQ3 = 2'h3;
  // write ceilings 16,32,48,64,96,100; wait count is index plus base
  localparam logic [41:0] FCA_WR_CEIL = 42'h326_080C_1010;
  localparam int FCA_WR_N = 6;
  localparam logic [3:0] FCA_WR_BASE = 4'h3;
  localparam int FCA_WR_TD_IDX = 3;
  localparam int FCA_WR_WSH_IDX = 5;

  // ************************************************************
  // controller register map (byte offsets on apb)
  // ************************************************************
  localparam logic [11:0] FCA_R_CTRL = 12'h000;
  localparam logic [11:0] FCA_R_PRESET = 12'h004;
  localparam logic [11:0] FCA_R_TIMING = 12'h008;
  localparam logic [11:0] FCA_R_ADDR = 12'h00C;
  localparam logic [11:0] FCA_R_WDATA = 12'h010;
  localparam logic [11:0] FCA_R_CMD = 12'h014;
  localparam logic [11:0] FCA_R_STATUS = 12'h018;
  localparam logic [11:0] FCA_R_RDATA = 12'h01C;
  localparam logic [11:0] FCA_R_PROG = 12'h020;
  localparam int FCA_ST_BUSY = 0;
  localparam int FCA_ST_DONE = 1;
  localparam int FCA_ST_ERR = 2;

endpackage

// ==== rtl/fca_if.sv ====
// Purpose: link between the cpu-side controller and the flash access end
// Assumes: both ends run on the same core clock
// Notes: request held until req_ready; rsp_valid is a one-cycle pulse

`timescale 1ns/1ps

interface fca_if;
  import fca_pkg::*;
  logic req_valid;            // request pending
  logic req_ready;            // access end idle, request taken
  fca_op_e req_op;            // read, write or fetch
  logic [31:0] req_addr;      // cpu byte address
  logic [31:0] req_wdata;     // write data, low half in 16-bit mode
  logic rsp_valid;            // answer pulse
  logic rsp_err;              // access refused
  logic [31:0] rsp_rdata;     // read data
  logic [21:0] rsp_fa;        // translated macro address
  fca_mode_e mode;            // access width mode
  fca_timing_s timing;        // wait and timing fields

  modport dev (input req_valid, req_op, req_addr, req_wdata, mode, timing,
               output req_ready, rsp_valid, rsp_err, rsp_rdata, rsp_fa);
  modport ctl (output req_valid, req_op, req_addr, req_wdata, mode, timing,
               input req_ready, rsp_valid, rsp_err, rsp_rdata, rsp_fa);
endinterface

// ==== rtl/fca_addr_map.sv ====
// Purpose: cpu address to flash macro address translation
// Assumes: byte addresses; purely combinational
// Notes: bit 2 of the cpu address picks the odd sector bank

`timescale 1ns/1ps

module fca_addr_map
  import fca_pkg::*;
(
  input wire logic [31:0] addr_in,
  output logic [FCA_FA_W-1:0] fa_out,
  output logic hit_out
);

  // ************************************************************
  // region decode and interleave arithmetic
  // ************************************************************
  always_comb
  begin
    logic [31:0] off;
    logic [31:0] fa;
    off = 32'h0000_0000;
    fa = 32'h0000_0000;
    hit_out = 1'b0;
    // halving the window offset folds even and odd banks together
    if (addr_in >= FCA_S8_LO && addr_in <= FCA_S8_HI)
    begin
      off = addr_in & (FCA_S8_WIN - 32'h0000_0001);
      fa = addr_in - off + (off >> 1) + (addr_in[2] ? FCA_S8_ODD : 32'h0000_0000)
           - {30'h0, addr_in[2:1]} + {30'h0, addr_in[1:0]} - FCA_S8_ADJ;
      hit_out = 1'b1;
    end
    else if (addr_in >= FCA_S64_LO && addr_in <= FCA_S64_HI)
    begin
      off = addr_in & (FCA_S64_WIN - 32'h0000_0001);
      fa = addr_in - off + (off >> 1) + (addr_in[2] ? FCA_S64_ODD : 32'h0000_0000)
           - {30'h0, addr_in[2:1]} + {30'h0, addr_in[1:0]} + FCA_S64_ADJ;
      hit_out = 1'b1;
    end
    fa_out = fa[FCA_FA_W-1:0];
  end

endmodule

// ==== rtl/fca_flash_end.sv ====
// Purpose: flash access end, turns link requests into macro cycles
// Assumes: macro is synchronous on the core clock, data valid at end of wait
// Notes: one access in flight; refused requests answer at once with error

`timescale 1ns/1ps

module fca_flash_end
  import fca_pkg::*;
(
  fca_if.dev LINK,
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  output logic [FCA_FA_W-1:0] FLASH_MACRO_ADDRESS_OUT,
  output logic FLASH_RD_OUT,
  output logic FLASH_WR_OUT,
  output logic [1:0] FLASH_WIDTH_OUT,
  output logic [31:0] FLASH_WDATA_OUT,
  input wire logic [63:0] FLASH_RDATA_IN,
  output logic TRANSITION_DETECT_SETTING_OUT,
  output logic ADDRESS_LATCH_HOLD_SETTING_OUT,
  output logic [1:0] EQUALIZE_SETTING_OUT,
  output logic WRITE_STROBE_HIGH_SETTING_OUT
);

  // ************************************************************
  // state
  // ************************************************************
  typedef enum logic [1:0] {DEV_IDLE, DEV_WAIT, DEV_RESP} fca_dev_state_e;

  typedef struct packed {
    fca_dev_state_e state;      // sequencer
    fca_mode_e mode;            // mode latched for the access
    logic hi_word;              // upper half of a 64-bit unit wanted
    logic [3:0] cnt;            // wait cycles left
    logic [FCA_FA_W-1:0] fa;    // macro address
    logic rd;                   // read strobe
    logic wr;                   // write strobe
    logic [31:0] wdata;         // write data to macro
    logic td;                   // transition detect
    logic address_latch_hold_setting;                 // address latch hold
    logic [1:0] eq;             // equalize
    logic wsh;                  // write strobe high
    logic rsp_valid;            // answer pulse
    logic rsp_err;              // answer is a refusal
    logic [31:0] rdata;         // captured read data
  } fca_dev_s;

  fca_dev_s r;        // registered state
  fca_dev_s n;        // next state
  logic [FCA_FA_W-1:0] map_fa;   // translator result
  logic map_hit;                 // address falls in a flash region

  // ************************************************************
  // address translator
  // ************************************************************
  fca_addr_map u_map (
    .addr_in(LINK.req_addr),
    .fa_out(map_fa),
    .hit_out(map_hit)
  );

  // ************************************************************
  // request checks
  // ************************************************************
  logic is_wr;     // write request
  logic refuse;    // request cannot be served
  logic in_sv;     // address inside the security vectors
  logic [3:0] wait_cnt;   // wait count for this access

  always_comb
  begin
    is_wr = (LINK.req_op == FCA_OP_WRITE);
    in_sv = (LINK.req_addr >= FCA_SV_LO) && (LINK.req_addr <= FCA_SV_HI);
    refuse = 1'b0;
    if (!map_hit || LINK.mode == FCA_MODE_BAD || LINK.req_op == FCA_OP_NONE)
    begin
      refuse = 1'b1;
    end
    // the wide path only ever reads, the array cannot be written here
    if (is_wr && LINK.mode == FCA_MODE64)
    begin
      refuse = 1'b1;
    end
    // half-word mode has no fetch path
    if (LINK.req_op == FCA_OP_FETCH && LINK.mode == FCA_MODE16)
    begin
      refuse = 1'b1;
    end
    // vectors steer protection, cpu writes there would defeat it
    if (is_wr && in_sv)
    begin
      refuse = 1'b1;
    end
    wait_cnt = is_wr ? LINK.timing.wr_wait : LINK.timing.rd_wait;
    // a zero count still costs one cycle so data has time to settle
    if (wait_cnt == 4'h0)
    begin
      wait_cnt = 4'h1;
    end
  end

  // ************************************************************
  // sequencer
  // ************************************************************
  always_comb
  begin
    n = r;
    n.rsp_valid = 1'b0;
    case (r.state)
      DEV_IDLE:
      begin
        if (LINK.req_valid)
        begin
          n.mode = LINK.mode;
          n.hi_word = LINK.req_addr[2];
          n.rsp_err = refuse;
          if (refuse)
          begin
            // answer without touching the array
            n.state = DEV_RESP;
            n.rsp_valid = 1'b1;
            n.rdata = 32'h0000_0000;
          end
          else
          begin
            n.state = DEV_WAIT;
            n.cnt = wait_cnt;
            n.rd = !is_wr;
            n.wr = is_wr;
            n.td = is_wr ? LINK.timing.td_wr : LINK.timing.td_rd;
            n.address_latch_hold_setting = is_wr ? 1'b0 : LINK.timing.address_latch_hold_setting;
            n.eq = is_wr ? 2'h0 : LINK.timing.eq;
            n.wsh = is_wr ? LINK.timing.wsh : 1'b0;
            case (LINK.mode)
              // whole double word, both banks at once
              FCA_MODE64: n.fa = {map_fa[FCA_FA_W-1:2], 2'b00};
              FCA_MODE32: n.fa = {map_fa[FCA_FA_W-1:2], 2'b00};
              // half-word granularity keeps bit 1
              default: n.fa = {map_fa[FCA_FA_W-1:1], 1'b0};
            endcase
            n.wdata = (LINK.mode == FCA_MODE16) ?
                      {16'h0000, LINK.req_wdata[15:0]} : LINK.req_wdata;
          end
        end
      end
      DEV_WAIT:
      begin
        if (r.cnt == 4'h1)
        begin
          // last wait cycle: take the data and end the strobes
          n.state = DEV_RESP;
          n.rsp_valid = 1'b1;
          n.rd = 1'b0;
          n.wr = 1'b0;
          n.cnt = 4'h0;
          case (r.mode)
            // one cpu word out of the 64-bit unit
            FCA_MODE64: n.rdata = r.hi_word ? FLASH_RDATA_IN[63:32]
                                            : FLASH_RDATA_IN[31:0];
            FCA_MODE32: n.rdata = FLASH_RDATA_IN[31:0];
            default: n.rdata = {16'h0000, FLASH_RDATA_IN[15:0]};
          endcase
          if (r.wr)
          begin
            n.rdata = 32'h0000_0000;
          end
        end
        else
        begin
          n.cnt = r.cnt - 4'h1;
        end
      end
      DEV_RESP:
      begin
        // answer stood one cycle, ready again
        n.state = DEV_IDLE;
      end
      default:
      begin
        n.state = DEV_IDLE;
      end
    endcase
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign LINK.req_ready = (r.state == DEV_IDLE);
  assign LINK.rsp_valid = r.rsp_valid;
  assign LINK.rsp_err = r.rsp_err;
  assign LINK.rsp_rdata = r.rdata;
  assign LINK.rsp_fa = r.fa;
  assign FLASH_MACRO_ADDRESS_OUT = r.fa;
  assign FLASH_RD_OUT = r.rd;
  assign FLASH_WR_OUT = r.wr;
  assign FLASH_WIDTH_OUT = r.mode;
  assign FLASH_WDATA_OUT = r.wdata;
  assign TRANSITION_DETECT_SETTING_OUT = r.td;
  assign ADDRESS_LATCH_HOLD_SETTING_OUT = r.address_latch_hold_setting;
  assign EQUALIZE_SETTING_OUT = r.eq;
  assign WRITE_STROBE_HIGH_SETTING_OUT = r.wsh;

endmodule

// ==== rtl/fca_cpu_end.sv ====
// Purpose: cpu-side controller, apb registers drive link requests
// Assumes: apb on the core clock, zero-wait slave
// Notes: one command at a time; done and error status flags are write-one-to-clear, busy is not

`timescale 1ns/1ps

module fca_cpu_end
  import fca_pkg::*;
(
  fca_if.ctl LINK,
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    fca_mode_e mode;          // width mode
    fca_timing_s timing;      // timing fields
    logic [31:0] addr;        // command address
    logic [31:0] wdata;       // command write data
    fca_op_e op;              // command operation
    logic busy;               // command outstanding
    logic req_valid;          // request on the link
    logic done;               // sticky completion
    logic err;                // sticky refusal
    logic [31:0] rdata;       // last read data
    logic [21:0] fa;          // last macro address
    logic [31:0] prdata;      // apb read data
    logic slverr;             // apb error
  } fca_cpu_s;

  fca_cpu_s r;
  fca_cpu_s n;

  // ************************************************************
  // timing presets by core clock ceiling
  // ************************************************************
  function automatic fca_timing_s preset(input logic [6:0] mhz);
    fca_timing_s t;
    int i;
    t = '0;
    // read side, three bands
    if (mhz <= FCA_RD_C1)
    begin
      t.rd_wait = FCA_RD_W1;
    end
    else if (mhz <= FCA_RD_C2)
    begin
      t.eq = FCA_EQ2;
      t.rd_wait = FCA_RD_W2;
    end
    else
    begin
      t.td_rd = 1'b1;
      t.address_latch_hold_setting = 1'b1;
      t.eq = FCA_EQ3;
      t.rd_wait = FCA_RD_W3;
    end
    // write side, lowest band that fits wins; above 100 MHz keep the slowest
    t.wr_wait = FCA_WR_BASE + 4'(FCA_WR_N - 1);
    t.td_wr = 1'b1;
    t.wsh = 1'b1;
    for (i = FCA_WR_N - 1; i >= 0; i--)
    begin
      if (mhz <= FCA_WR_CEIL[i*7 +: 7])
      begin
        t.wr_wait = FCA_WR_BASE + 4'(i);
        t.td_wr = (i >= FCA_WR_TD_IDX);
        t.wsh = (i >= FCA_WR_WSH_IDX);
      end
    end
    return t;
  endfunction

  // ************************************************************
  // apb and command handling
  // ************************************************************
  logic setup;   // apb setup cycle
  logic wr_acc;  // apb write taking effect
  logic unmapped;

  always_comb
  begin
    logic [31:0] clr;
    clr = 32'h0000_0000;
    setup = PSEL_IN && !PENABLE_IN;
    wr_acc = PSEL_IN && PENABLE_IN && PWRITE_IN && !r.slverr;
    unmapped = (PADDR_IN > FCA_R_PROG) || (PADDR_IN[1:0] != 2'b00);
    n = r;
    if (r.req_valid && LINK.req_ready)
    begin
      n.req_valid = 1'b0;
    end
    if (setup)
    begin
      // data fetched in setup so it is a flop during access
      case (PADDR_IN)
        FCA_R_CTRL: n.prdata = {30'h0, r.mode};
        FCA_R_TIMING: n.prdata = {18'h0, r.timing};
        FCA_R_ADDR: n.prdata = r.addr;
        FCA_R_WDATA: n.prdata = r.wdata;
        FCA_R_STATUS: n.prdata = {29'h0, r.err, r.done, r.busy};
        FCA_R_RDATA: n.prdata = r.rdata;
        // address as a parallel programmer sees it
        FCA_R_PROG: n.prdata = {10'h0, r.fa | FCA_PROG_OFS};
        default: n.prdata = 32'h0000_0000;
      endcase
      n.slverr = unmapped || (PWRITE_IN && PADDR_IN == FCA_R_CMD && r.busy);
    end
    if (wr_acc)
    begin
      case (PADDR_IN)
        FCA_R_CTRL: n.mode = fca_mode_e'(PWDATA_IN[1:0]);
        FCA_R_PRESET: n.timing = preset(PWDATA_IN[6:0]);
        FCA_R_TIMING: n.timing = fca_timing_s'(PWDATA_IN[$bits(fca_timing_s)-1:0]);
        FCA_R_ADDR: n.addr = PWDATA_IN;
        FCA_R_WDATA: n.wdata = PWDATA_IN;
        FCA_R_CMD:
        begin
          n.op = fca_op_e'(PWDATA_IN[1:0]);
          n.busy = 1'b1;
          n.req_valid = 1'b1;
        end
        FCA_R_STATUS: clr = PWDATA_IN;
        default: n.busy = r.busy;
      endcase
    end
    // a completion in the clearing cycle is kept
    n.done = (r.done && !clr[FCA_ST_DONE]) || LINK.rsp_valid;
    n.err = (r.err && !clr[FCA_ST_ERR]) || (LINK.rsp_valid && LINK.rsp_err);
    if (LINK.rsp_valid)
    begin
      n.busy = 1'b0;
      n.rdata = LINK.rsp_rdata;
      n.fa = LINK.rsp_fa;
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign PREADY_OUT = PSEL_IN && PENABLE_IN;
  assign PRDATA_OUT = r.prdata;
  assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && r.slverr;
  assign LINK.req_valid = r.req_valid;
  assign LINK.req_op = r.op;
  assign LINK.req_addr = r.addr;
  assign LINK.req_wdata = r.wdata;
  assign LINK.mode = r.mode;
  assign LINK.timing = r.timing;

endmodule

// ==== testbench/fca_link_monitor.sv ====
// Purpose: checks the link between the cpu end and the flash end
// Assumes: one core clock, reset active low
// Notes: watches link signals and the macro strobes

`timescale 1ns/1ps

module fca_link_monitor (
  input logic CLK_IN,
  input logic RST_B_IN,
  input logic req_valid,
  input logic req_ready,
  input fca_pkg::fca_op_e req_op,
  input logic [31:0] req_addr,
  input logic rsp_valid,
  input logic rsp_err,
  input logic [21:0] rsp_fa,
  input fca_pkg::fca_mode_e mode,
  input fca_pkg::fca_timing_s timing,
  input logic FLASH_RD_OUT,
  input logic FLASH_WR_OUT,
  input logic [1:0] FLASH_WIDTH_OUT
);
  import fca_pkg::*;
  logic take;        // request accepted this cycle
  logic stb;         // macro strobe of either kind
  logic sv_hit;      // address in the reserved vector words
  logic [4:0] cnt_r; // cycles the strobe has stood
  logic [4:0] rd_n;  // read wait, zero acts as one
  logic [4:0] wr_n;  // write wait, zero acts as one
  assign take = req_valid && req_ready;
  assign stb = FLASH_RD_OUT || FLASH_WR_OUT;
  assign sv_hit = req_addr >= FCA_SV_LO && req_addr <= FCA_SV_HI;
  assign rd_n = (timing.rd_wait == 4'h0) ? 5'h1 : {1'b0, timing.rd_wait};
  assign wr_n = (timing.wr_wait == 4'h0) ? 5'h1 : {1'b0, timing.wr_wait};

  // ****
  // strobe length counter, cleared whenever the strobe is low
  // ****
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
      cnt_r <= 5'h0;
    else
      cnt_r <= stb ? cnt_r + 5'h1 : 5'h0;
  end

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_B_IN);

  no_write64_a: assert property (
    take && mode == FCA_MODE64 && req_op == FCA_OP_WRITE |=> rsp_valid && rsp_err)
    else $error("write in widest mode not refused");
  no_fetch16_a: assert property (
    take && mode == FCA_MODE16 && req_op == FCA_OP_FETCH |=> rsp_valid && rsp_err)
    else $error("fetch in half mode not refused");
  vector_guard_a: assert property (
    take && req_op == FCA_OP_WRITE && sv_hit |=> rsp_valid && rsp_err)
    else $error("write to vector words not refused");
  rd_stretch_a: assert property ($fell(FLASH_RD_OUT) |-> cnt_r == rd_n)
    else $error("read strobe length wrong");
  wr_stretch_a: assert property ($fell(FLASH_WR_OUT) |-> cnt_r == wr_n)
    else $error("write strobe length wrong");
  answer_end_a: assert property ($fell(stb) |-> rsp_valid && !rsp_err)
    else $error("no answer as strobe ends");
  width_mode_a: assert property (stb |-> FLASH_WIDTH_OUT == mode)
    else $error("array access width wrong");
  fa_align_a: assert property (
    rsp_valid && !rsp_err |-> !rsp_fa[0] && (mode == FCA_MODE16 || !rsp_fa[1]))
    else $error("macro address misaligned");
  pulse_ready_a: assert property (rsp_valid |=> !rsp_valid && req_ready)
    else $error("answer not one cycle");
  hold_req_a: assert property (
    req_valid && !req_ready |=> req_valid && $stable(req_addr) && $stable(req_op))
    else $error("request dropped while waiting");
endmodule

// ==== testbench/flash_cpu_access_interface_test.sv ====
// Purpose: drives the cpu end over apb and checks the flash path end to end
// Assumes: both ends on one clock; macro data comes from the bench
// Notes: fixed seed; a cycle ceiling cuts a hang short

`timescale 1ns/1ps

`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin errors++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end

module flash_cpu_access_interface_test;
  import fca_pkg::*;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, f_rd, f_wr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [63:0] flash_rdata; // macro word seen by the flash end
  logic [1:0] f_width;
  int errors, samples_checked, cycles, seed;
  fca_if link();
  fca_cpu_end i_fca_cpu_end(.LINK(link), .CLK_IN(clk), .RST_B_IN(rst_b), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr));
  fca_flash_end i_fca_flash_end(.LINK(link), .CLK_IN(clk), .RST_B_IN(rst_b),
    .FLASH_MACRO_ADDRESS_OUT(), .FLASH_RD_OUT(f_rd), .FLASH_WR_OUT(f_wr),
    .FLASH_WIDTH_OUT(f_width), .FLASH_WDATA_OUT(), .FLASH_RDATA_IN(flash_rdata),
    .TRANSITION_DETECT_SETTING_OUT(), .ADDRESS_LATCH_HOLD_SETTING_OUT(),
    .EQUALIZE_SETTING_OUT(), .WRITE_STROBE_HIGH_SETTING_OUT());
  fca_link_monitor i_fca_link_monitor(.CLK_IN(clk), .RST_B_IN(rst_b),
    .req_valid(link.req_valid), .req_ready(link.req_ready), .req_op(link.req_op),
    .req_addr(link.req_addr), .rsp_valid(link.rsp_valid), .rsp_err(link.rsp_err),
    .rsp_fa(link.rsp_fa), .mode(link.mode), .timing(link.timing), .FLASH_RD_OUT(f_rd),
    .FLASH_WR_OUT(f_wr), .FLASH_WIDTH_OUT(f_width));

  always #4 clk = ~clk;

  // cycle ceiling: the whole run needs some 2000 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      end_sim();
    end
  end

  task automatic end_sim;
    if (errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // one apb transfer; waits for pready however long it takes
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask

  task automatic wait_done(output logic [31:0] r);
    r = 32'h0;
    while (r[FCA_ST_DONE] !== 1'b1) rd(FCA_R_STATUS, r);
  endtask

  // odd bank offset is half the window; s picks the smaller variants' constants
  function automatic logic [31:0] exp_fa(input logic [31:0] a, input logic s);
    logic [31:0] w;
    w = (a >= FCA_S8_LO) ? FCA_S8_WIN : FCA_S64_WIN;
    exp_fa = a - a % w + (a % w) / 2 + (a[2] ? w / 2 : 32'h0) - (a / 2) % 4 + a % 4
      + ((a >= FCA_S8_LO) ? (s ? -32'h000D_0000 : -FCA_S8_ADJ) : (s ? '0 : FCA_S64_ADJ));
  endfunction

  function automatic logic exp_err(input fca_mode_e m, input fca_op_e o, input logic [31:0] a);
    exp_err = a < FCA_S64_LO || a > FCA_S8_HI || m == FCA_MODE_BAD || o == FCA_OP_NONE
      || (o == FCA_OP_WRITE && (m == FCA_MODE64 || (a >= FCA_SV_LO && a <= FCA_SV_HI)))
      || (o == FCA_OP_FETCH && m == FCA_MODE16);
  endfunction

  function automatic logic [31:0] exp_tim(input int f);
    fca_timing_s t;
    t = '0;
    t.rd_wait = (f <= 24) ? 4'h1 : (f <= 48) ? 4'h2 : 4'h4;
    t.eq = (f <= 24) ? 2'h0 : (f <= 48) ? 2'h1 : 2'h3;
    t.td_rd = f > 48;
    t.address_latch_hold_setting = f > 48;
    t.wr_wait = (f <= 16) ? 4'h3 : (f <= 32) ? 4'h4 : (f <= 48) ? 4'h5 :
      (f <= 64) ? 4'h6 : (f <= 96) ? 4'h7 : 4'h8;
    t.td_wr = f > 48;
    t.wsh = f > 96;
    exp_tim = {18'h0, t};
  endfunction

  // one command through the registers, then status, data and address
  task automatic run_op(input fca_mode_e m, input fca_op_e o, input logic [31:0] a);
    logic [31:0] r, x;
    flash_rdata <= {$random(seed), $random(seed)};
    wr(FCA_R_CTRL, {30'h0, m});
    wr(FCA_R_ADDR, a);
    wr(FCA_R_WDATA, $random(seed));
    wr(FCA_R_CMD, {30'h0, o});
    wait_done(r);
    `CHK("err", exp_err(m, o, a), r[FCA_ST_ERR])
    if (!exp_err(m, o, a))
    begin
      x = (o == FCA_OP_WRITE) ? 32'h0 : (m == FCA_MODE64 && a[2]) ? flash_rdata[63:32] :
        (m == FCA_MODE16) ? {16'h0, flash_rdata[15:0]} : flash_rdata[31:0];
      rd(FCA_R_RDATA, r);
      `CHK("rdata", x, r)
      rd(FCA_R_PROG, r);
      `CHK("fa", exp_fa(a, 1'b0) | 32'h0020_0000, r)
      x = r[20:0] - ((a < FCA_S8_LO) ? 21'h0C_0000 : 21'h08_0000);
      `CHK("fa small", exp_fa(a, 1'b1) | 32'h0010_0000, x | 32'h0010_0000)
    end
    wr(FCA_R_STATUS, 32'h6);
  endtask

  initial
  begin
    fca_mode_e m;
    fca_op_e o;
    logic [31:0] a, r;
    logic e;
    int fq[15] = '{1, 16, 17, 24, 25, 32, 33, 48, 49, 64, 65, 96, 97, 100, 127};
    clk = 1'b0;
    rst_b = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, flash_rdata} = '0;
    {errors, samples_checked, cycles} = '0;
    seed = 92012;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rd(FCA_R_TIMING, r);
    `CHK("timing reset", 32'h0, r)
    foreach (fq[i])
    begin
      wr(FCA_R_PRESET, fq[i]);
      rd(FCA_R_TIMING, r);
      `CHK("preset", exp_tim(fq[i]), r)
    end
    apb(1'b0, 12'h024, 32'h0, r, e);
    `CHK("unmapped", 1'b1, e)
    apb(1'b0, 12'h006, 32'h0, r, e);
    `CHK("unaligned", 1'b1, e)
    run_op(FCA_MODE32, FCA_OP_READ, 32'h0004_0000);
    run_op(FCA_MODE64, FCA_OP_READ, 32'h0013_FFFC);
    run_op(FCA_MODE16, FCA_OP_WRITE, 32'h0014_0006);
    run_op(FCA_MODE32, FCA_OP_FETCH, 32'h0014_FFFC);
    run_op(FCA_MODE32, FCA_OP_WRITE, 32'h0014_8004);
    run_op(FCA_MODE16, FCA_OP_READ, 32'h0014_800E);
    run_op(FCA_MODE32, FCA_OP_READ, 32'h0003_FFFC);
    run_op(FCA_MODE16, FCA_OP_READ, 32'h0015_0000);
    run_op(FCA_MODE64, FCA_OP_WRITE, 32'h0004_0000);
    run_op(FCA_MODE16, FCA_OP_FETCH, 32'h0005_0000);
    run_op(FCA_MODE_BAD, FCA_OP_READ, 32'h0005_0000);
    run_op(FCA_MODE32, FCA_OP_NONE, 32'h0005_0000);
    // second command while the first is still waiting on the macro
    wr(FCA_R_TIMING, 32'h3C00);
    wr(FCA_R_CMD, {30'h0, FCA_OP_READ});
    apb(1'b1, FCA_R_CMD, {30'h0, FCA_OP_READ}, r, e);
    `CHK("busy cmd", 1'b1, e)
    wait_done(r);
    wr(FCA_R_STATUS, 32'h6);
    repeat (40)
    begin
      m = fca_mode_e'($unsigned($random(seed)) % 3);
      o = fca_op_e'($unsigned($random(seed)) % 3);
      a = FCA_S64_LO + $unsigned($random(seed)) % 32'h0011_0000;
      a[1:0] = (m == FCA_MODE16) ? {a[1], 1'b0} : 2'h0;
      wr(FCA_R_TIMING, $random(seed) & 32'h3FFF);
      run_op(m, o, a);
    end
    end_sim();
  end
endmodule
